// ### rtl/iorb_pkg.sv
// constants, types and register map of the i/o read, accumulator and branch unit
// Notes on behaviour
// - bank 0 read returns input line level
// - inputs readable digitally and analogue concurrently
// - bank 1 read returns 16-bit conversion
// - bank 2 read returns output line state
// - instruction 19 applies operation into accumulator
// - codes 0-4 add sub mul div mod
// - 5-7 and/or/xor, 8 invert, 9 load
// - direct arith reply status 100, operand echoed
// - instruction 20 compares, sets status flags
// - instruction 21 jumps when condition holds, refused in direct mode
// - arithmetic conditions use latest compare flags
// - codes 0-7 zero..lower-or-equal in order
// - codes 8-11 test the four error flags
// - standalone read loads accumulator, direct does not
// - instruction 15 reads, type port, bank selects
package iorb_pkg;

  localparam int ADDR_W = 12;
  localparam int NUM_LINES = 4;
  localparam int ADC_W = 16;

  localparam logic [7:0] OP_READ_IO_PORT = 8'h0F;
  localparam logic [7:0] OP_ACCUM_ARITH = 8'h13;
  localparam logic [7:0] OP_COMPARE = 8'h14;
  localparam logic [7:0] OP_COND_BRANCH = 8'h15;

  localparam logic [7:0] ARITH_ADD = 8'h00;
  localparam logic [7:0] ARITH_SUB = 8'h01;
  localparam logic [7:0] ARITH_MUL = 8'h02;
  localparam logic [7:0] ARITH_DIV = 8'h03;
  localparam logic [7:0] ARITH_MOD = 8'h04;
  localparam logic [7:0] ARITH_AND = 8'h05;
  localparam logic [7:0] ARITH_OR = 8'h06;
  localparam logic [7:0] ARITH_XOR = 8'h07;
  localparam logic [7:0] ARITH_NOT = 8'h08;
  localparam logic [7:0] ARITH_LOAD = 8'h09;

  localparam logic [7:0] COND_ZERO = 8'h00;
  localparam logic [7:0] COND_NONZERO = 8'h01;
  localparam logic [7:0] COND_EQUAL = 8'h02;
  localparam logic [7:0] COND_NOT_EQUAL = 8'h03;
  localparam logic [7:0] COND_GREATER = 8'h04;
  localparam logic [7:0] COND_GREATER_EQUAL = 8'h05;
  localparam logic [7:0] COND_LOWER = 8'h06;
  localparam logic [7:0] COND_LOWER_EQUAL = 8'h07;
  localparam logic [7:0] COND_TIMEOUT_ERR = 8'h08;
  localparam logic [7:0] COND_EXT_ALARM = 8'h09;
  localparam logic [7:0] COND_DEVIATION_ERR = 8'h0A;
  localparam logic [7:0] COND_POSITION_ERR = 8'h0B;

  localparam logic [7:0] BANK_DIGITAL_IN = 8'h00;
  localparam logic [7:0] BANK_ANALOGUE_IN = 8'h01;
  localparam logic [7:0] BANK_OUTPUT_STATE = 8'h02;
  localparam logic [7:0] PORT_MAX = 8'h03;

  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] STATUS_REJECT = 8'h02;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_OPERAND = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_COMMAND = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_REPLY_STATUS = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_REPLY_VALUE = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_ACCUM = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_PROG_COUNTER = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 12'h01C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h024;

  localparam int CMD_INSTR_LSB = 0;
  localparam int CMD_TYPE_LSB = 8;
  localparam int CMD_BANK_LSB = 16;
  localparam int CTRL_STANDALONE_BIT = 0;
  localparam int REPLY_BUSY_BIT = 8;

  localparam int FLAG_W = 3;
  localparam int FLAG_ZERO_BIT = 0;
  localparam int FLAG_GREATER_BIT = 1;
  localparam int FLAG_LOWER_BIT = 2;
  localparam int FLAG_ERR_LSB = 4;

  localparam int IRQ_W = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_BRANCH_BIT = 1;
  localparam int IRQ_REJECT_BIT = 2;

  localparam logic [31:0] ACC_RST = 32'h0000_0000;
  localparam logic [31:0] PC_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic {ST_IDLE, ST_EXEC} iorb_state_e;

endpackage

// ### rtl/iorb_alu.sv
// accumulator arithmetic and logic with a constant operand
`timescale 1ns/1ps
module iorb_alu (
  input wire logic [31:0] acc,
  input wire logic [31:0] operand,
  input wire logic [7:0] op,
  output logic [31:0] result,
  output logic valid
);
  logic signed [31:0] a;
  logic signed [31:0] b;

  // both sides are two's complement words
  assign a = acc;
  assign b = operand;

  always_comb begin
    result = acc;
    valid = 1'b1;
    unique case (op)
      iorb_pkg::ARITH_ADD: result = a + b;
      iorb_pkg::ARITH_SUB: result = a - b;
      iorb_pkg::ARITH_MUL: result = a * b;
      // division by zero refused, accumulator kept
      iorb_pkg::ARITH_DIV: begin
        valid = (b != 32'sh0000_0000);
        result = valid ? a / b : a;
      end
      iorb_pkg::ARITH_MOD: begin
        valid = (b != 32'sh0000_0000);
        result = valid ? a % b : a;
      end
      iorb_pkg::ARITH_AND: result = acc & operand;
      iorb_pkg::ARITH_OR: result = acc | operand;
      iorb_pkg::ARITH_XOR: result = acc ^ operand;
      iorb_pkg::ARITH_NOT: result = ~acc;
      iorb_pkg::ARITH_LOAD: result = operand;
      default: valid = 1'b0;
    endcase
  end
endmodule

// ### rtl/iorb_cond.sv
// branch condition evaluation from compare flags and error flags
`timescale 1ns/1ps
module iorb_cond (
  input wire logic [iorb_pkg::FLAG_W-1:0] flags,
  input wire logic [3:0] err,
  input wire logic [7:0] code,
  output logic take,
  output logic valid
);
  logic z;
  logic g;
  logic l;

  assign z = flags[iorb_pkg::FLAG_ZERO_BIT];
  assign g = flags[iorb_pkg::FLAG_GREATER_BIT];
  assign l = flags[iorb_pkg::FLAG_LOWER_BIT];

  always_comb begin
    take = 1'b0;
    valid = 1'b1;
    unique case (code)
      iorb_pkg::COND_ZERO: take = z;
      iorb_pkg::COND_NONZERO: take = ~z;
      iorb_pkg::COND_EQUAL: take = z;
      iorb_pkg::COND_NOT_EQUAL: take = ~z;
      iorb_pkg::COND_GREATER: take = g;
      iorb_pkg::COND_GREATER_EQUAL: take = g | z;
      iorb_pkg::COND_LOWER: take = l;
      iorb_pkg::COND_LOWER_EQUAL: take = l | z;
      iorb_pkg::COND_TIMEOUT_ERR: take = err[0];
      iorb_pkg::COND_EXT_ALARM: take = err[1];
      iorb_pkg::COND_DEVIATION_ERR: take = err[2];
      iorb_pkg::COND_POSITION_ERR: take = err[3];
      default: valid = 1'b0;
    endcase
  end
endmodule

// ### rtl/iorb_top.sv
// command engine for port reads, accumulator arithmetic, compare and conditional branch
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module iorb_top (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [iorb_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [iorb_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [iorb_pkg::NUM_LINES-1:0] INPUT_LINE_LEVEL,
  input wire logic [iorb_pkg::ADC_W-1:0] INPUT_LINE_ADC_0,
  input wire logic [iorb_pkg::ADC_W-1:0] INPUT_LINE_ADC_1,
  input wire logic [iorb_pkg::ADC_W-1:0] INPUT_LINE_ADC_2,
  input wire logic [iorb_pkg::ADC_W-1:0] INPUT_LINE_ADC_3,
  input wire logic [iorb_pkg::NUM_LINES-1:0] OUTPUT_LINE_STATE,
  input wire logic TIMEOUT_ERROR_FLAG,
  input wire logic EXTERNAL_ALARM_FLAG,
  input wire logic DEVIATION_ERROR_FLAG,
  input wire logic POSITION_ERROR_FLAG,
  output logic IRQ
);

  // register file
  logic aw_ready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic ar_ready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic standalone_reg;
  logic [31:0] operand_reg;
  logic [7:0] instr_reg;
  logic [7:0] type_reg;
  logic [7:0] bank_reg;
  logic [7:0] status_reg;
  logic [31:0] reply_reg;
  logic [31:0] acc_reg;
  logic [31:0] pc_reg;
  logic [iorb_pkg::FLAG_W-1:0] flags_reg;
  logic [iorb_pkg::IRQ_W-1:0] irq_status_reg;
  logic [iorb_pkg::IRQ_W-1:0] irq_mask_reg;
  logic irq_reg;
  iorb_pkg::iorb_state_e state_reg;

  logic wr_do;
  logic rd_do;
  logic exec;
  logic [iorb_pkg::ADC_W-1:0] adc_line [iorb_pkg::NUM_LINES];
  logic [3:0] err_flags;
  logic [31:0] port_val;
  logic port_ok;
  logic [31:0] alu_res;
  logic alu_ok;
  logic cond_take;
  logic cond_ok;
  logic cmd_ok;
  logic [31:0] reply_next;
  logic acc_we;
  logic [31:0] acc_next;
  logic flag_we;
  logic jump;
  logic [iorb_pkg::FLAG_W-1:0] flags_next;
  logic [iorb_pkg::IRQ_W-1:0] irq_set;
  logic irq_rd_clear;
  logic [iorb_pkg::IRQ_W-1:0] irq_status_next;
  logic [31:0] rd_word;

  function automatic logic is_mapped(input logic [iorb_pkg::ADDR_W-1:0] a);
    is_mapped = (a == iorb_pkg::OFS_CTRL) || (a == iorb_pkg::OFS_OPERAND) ||
                (a == iorb_pkg::OFS_COMMAND) || (a == iorb_pkg::OFS_REPLY_STATUS) ||
                (a == iorb_pkg::OFS_REPLY_VALUE) || (a == iorb_pkg::OFS_ACCUM) ||
                (a == iorb_pkg::OFS_PROG_COUNTER) || (a == iorb_pkg::OFS_FLAGS) ||
                (a == iorb_pkg::OFS_IRQ_STATUS) || (a == iorb_pkg::OFS_IRQ_MASK);
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] strb);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    merge_bytes = m;
  endfunction

  assign S_AXI_AWREADY = aw_ready_reg;
  assign S_AXI_WREADY = aw_ready_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_ARREADY = ar_ready_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign IRQ = irq_reg;

  // address and data are taken together in one beat
  assign wr_do = aw_ready_reg & S_AXI_AWVALID & S_AXI_WVALID;
  assign rd_do = ar_ready_reg & S_AXI_ARVALID;
  assign exec = (state_reg == iorb_pkg::ST_EXEC);

  // digital and analogue views sampled from separate ports, no mode switch
  assign adc_line[0] = INPUT_LINE_ADC_0;
  assign adc_line[1] = INPUT_LINE_ADC_1;
  assign adc_line[2] = INPUT_LINE_ADC_2;
  assign adc_line[3] = INPUT_LINE_ADC_3;
  assign err_flags = {POSITION_ERROR_FLAG, DEVIATION_ERROR_FLAG, EXTERNAL_ALARM_FLAG, TIMEOUT_ERROR_FLAG};

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      aw_ready_reg <= 1'b0;
    end else begin
      aw_ready_reg <= S_AXI_AWVALID & S_AXI_WVALID & ~aw_ready_reg & ~bvalid_reg;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= iorb_pkg::RESP_OKAY;
    end else if (wr_do) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= is_mapped(S_AXI_AWADDR) ? iorb_pkg::RESP_OKAY : iorb_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ar_ready_reg <= 1'b0;
    end else begin
      ar_ready_reg <= S_AXI_ARVALID & ~ar_ready_reg & ~rvalid_reg;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (S_AXI_ARADDR)
      iorb_pkg::OFS_CTRL: rd_word[iorb_pkg::CTRL_STANDALONE_BIT] = standalone_reg;
      iorb_pkg::OFS_OPERAND: rd_word = operand_reg;
      iorb_pkg::OFS_COMMAND: rd_word[23:0] = {bank_reg, type_reg, instr_reg};
      iorb_pkg::OFS_REPLY_STATUS: rd_word[8:0] = {exec, status_reg};
      iorb_pkg::OFS_REPLY_VALUE: rd_word = reply_reg;
      iorb_pkg::OFS_ACCUM: rd_word = acc_reg;
      iorb_pkg::OFS_PROG_COUNTER: rd_word = pc_reg;
      iorb_pkg::OFS_FLAGS: rd_word[7:0] = {err_flags, 1'b0, flags_reg};
      iorb_pkg::OFS_IRQ_STATUS: rd_word[iorb_pkg::IRQ_W-1:0] = irq_status_reg;
      iorb_pkg::OFS_IRQ_MASK: rd_word[iorb_pkg::IRQ_W-1:0] = irq_mask_reg;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= iorb_pkg::WORD_RST;
      rresp_reg <= iorb_pkg::RESP_OKAY;
    end else if (rd_do) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= is_mapped(S_AXI_ARADDR) ? iorb_pkg::RESP_OKAY : iorb_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // software-written configuration
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      standalone_reg <= 1'b0;
      operand_reg <= iorb_pkg::WORD_RST;
      irq_mask_reg <= iorb_pkg::IRQ_MASK_RST;
    end else if (wr_do) begin
      if (S_AXI_AWADDR == iorb_pkg::OFS_CTRL && S_AXI_WSTRB[0]) begin
        standalone_reg <= S_AXI_WDATA[iorb_pkg::CTRL_STANDALONE_BIT];
      end
      if (S_AXI_AWADDR == iorb_pkg::OFS_OPERAND) begin
        operand_reg <= merge_bytes(operand_reg, S_AXI_WDATA, S_AXI_WSTRB);
      end
      if (S_AXI_AWADDR == iorb_pkg::OFS_IRQ_MASK && S_AXI_WSTRB[0]) begin
        irq_mask_reg <= S_AXI_WDATA[iorb_pkg::IRQ_W-1:0];
      end
    end
  end

  // a command write launches one execution cycle
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      instr_reg <= 8'h00;
      type_reg <= 8'h00;
      bank_reg <= 8'h00;
      state_reg <= iorb_pkg::ST_IDLE;
    end else if (wr_do && S_AXI_AWADDR == iorb_pkg::OFS_COMMAND) begin
      instr_reg <= S_AXI_WSTRB[0] ? S_AXI_WDATA[iorb_pkg::CMD_INSTR_LSB +: 8] : instr_reg;
      type_reg <= S_AXI_WSTRB[1] ? S_AXI_WDATA[iorb_pkg::CMD_TYPE_LSB +: 8] : type_reg;
      bank_reg <= S_AXI_WSTRB[2] ? S_AXI_WDATA[iorb_pkg::CMD_BANK_LSB +: 8] : bank_reg;
      state_reg <= iorb_pkg::ST_EXEC;
    end else begin
      state_reg <= iorb_pkg::ST_IDLE;
    end
  end

  // port read: type picks the line, bank picks the view
  always_comb begin
    port_ok = (type_reg <= iorb_pkg::PORT_MAX) && (bank_reg <= iorb_pkg::BANK_OUTPUT_STATE);
    port_val = 32'h0000_0000;
    unique case (bank_reg)
      iorb_pkg::BANK_DIGITAL_IN: port_val[0] = INPUT_LINE_LEVEL[type_reg[1:0]];
      iorb_pkg::BANK_ANALOGUE_IN: port_val[iorb_pkg::ADC_W-1:0] = adc_line[type_reg[1:0]];
      iorb_pkg::BANK_OUTPUT_STATE: port_val[0] = OUTPUT_LINE_STATE[type_reg[1:0]];
      default: port_val = 32'h0000_0000;
    endcase
  end

  iorb_alu u_alu (
    .acc(acc_reg),
    .operand(operand_reg),
    .op(type_reg),
    .result(alu_res),
    .valid(alu_ok)
  );

  iorb_cond u_cond (
    .flags(flags_reg),
    .err(err_flags),
    .code(type_reg),
    .take(cond_take),
    .valid(cond_ok)
  );

  // signed comparison of accumulator against operand
  always_comb begin
    flags_next = iorb_pkg::FLAGS_RST;
    flags_next[iorb_pkg::FLAG_ZERO_BIT] = (acc_reg == operand_reg);
    flags_next[iorb_pkg::FLAG_GREATER_BIT] = ($signed(acc_reg) > $signed(operand_reg));
    flags_next[iorb_pkg::FLAG_LOWER_BIT] = ($signed(acc_reg) < $signed(operand_reg));
  end

  always_comb begin
    cmd_ok = 1'b0;
    reply_next = 32'h0000_0000;
    acc_we = 1'b0;
    acc_next = alu_res;
    flag_we = 1'b0;
    jump = 1'b0;
    unique case (instr_reg)
      iorb_pkg::OP_READ_IO_PORT: begin
        cmd_ok = port_ok;
        reply_next = port_val;
        acc_we = port_ok & standalone_reg;
        acc_next = port_val;
      end
      iorb_pkg::OP_ACCUM_ARITH: begin
        cmd_ok = alu_ok;
        reply_next = operand_reg;
        acc_we = alu_ok;
      end
      iorb_pkg::OP_COMPARE: begin
        cmd_ok = 1'b1;
        flag_we = 1'b1;
      end
      iorb_pkg::OP_COND_BRANCH: begin
        // a branch makes sense only inside a stored program
        cmd_ok = cond_ok & standalone_reg;
        jump = cond_ok & standalone_reg & cond_take;
        reply_next = operand_reg;
      end
      default: cmd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      acc_reg <= iorb_pkg::ACC_RST;
    end else if (exec && acc_we) begin
      acc_reg <= acc_next;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      flags_reg <= iorb_pkg::FLAGS_RST;
    end else if (exec && flag_we) begin
      flags_reg <= flags_next;
    end
  end

  // counter moves only for stored-program execution; software may preset it
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pc_reg <= iorb_pkg::PC_RST;
    end else if (exec && standalone_reg) begin
      pc_reg <= jump ? operand_reg : pc_reg + 32'h0000_0001;
    end else if (wr_do && S_AXI_AWADDR == iorb_pkg::OFS_PROG_COUNTER) begin
      pc_reg <= merge_bytes(pc_reg, S_AXI_WDATA, S_AXI_WSTRB);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      status_reg <= iorb_pkg::STATUS_RST;
      reply_reg <= iorb_pkg::WORD_RST;
    end else if (exec) begin
      status_reg <= cmd_ok ? iorb_pkg::STATUS_OK : iorb_pkg::STATUS_REJECT;
      reply_reg <= cmd_ok ? reply_next : 32'h0000_0000;
    end
  end

  // sticky events; a new event in the clearing read cycle survives
  always_comb begin
    irq_set = '0;
    irq_set[iorb_pkg::IRQ_DONE_BIT] = exec;
    irq_set[iorb_pkg::IRQ_BRANCH_BIT] = exec & jump;
    irq_set[iorb_pkg::IRQ_REJECT_BIT] = exec & ~cmd_ok;
  end

  assign irq_rd_clear = rd_do && (S_AXI_ARADDR == iorb_pkg::OFS_IRQ_STATUS);
  assign irq_status_next = (irq_rd_clear ? '0 : irq_status_reg) | irq_set;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      irq_status_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

endmodule

// ### test/iorb_properties.sv
// concurrent checks on the command engine's bus handshakes and flag view
`timescale 1ns/1ps
module iorb_properties (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [iorb_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic TIMEOUT_ERROR_FLAG,
  input wire logic EXTERNAL_ALARM_FLAG,
  input wire logic DEVIATION_ERROR_FLAG,
  input wire logic POSITION_ERROR_FLAG,
  input wire logic IRQ
);
  logic [3:0] err_now;
  assign err_now = {POSITION_ERROR_FLAG, DEVIATION_ERROR_FLAG, EXTERNAL_ALARM_FLAG, TIMEOUT_ERROR_FLAG};
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  property p_pair; S_AXI_AWREADY == S_AXI_WREADY; endproperty
  a_pair: assert property (p_pair) else $error("write readies differ");
  property p_aw_cause; $rose(S_AXI_AWREADY) |-> $past(S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID); endproperty
  a_aw_cause: assert property (p_aw_cause) else $error("write ready without both valids");
  property p_b_follow; S_AXI_AWREADY && S_AXI_AWVALID && S_AXI_WVALID |=> S_AXI_BVALID; endproperty
  a_b_follow: assert property (p_b_follow) else $error("no write response after handshake");
  property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_follow; S_AXI_ARREADY && S_AXI_ARVALID |=> S_AXI_RVALID; endproperty
  a_r_follow: assert property (p_r_follow) else $error("no read data after handshake");
  property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_ar_pulse; S_AXI_ARREADY |=> !S_AXI_ARREADY; endproperty
  a_ar_pulse: assert property (p_ar_pulse) else $error("read ready longer than one cycle");
  property p_unmapped;
    S_AXI_ARREADY && S_AXI_ARVALID && S_AXI_ARADDR > 12'h024 |=>
      S_AXI_RRESP == iorb_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_err_view;
    S_AXI_ARREADY && S_AXI_ARVALID && S_AXI_ARADDR == iorb_pkg::OFS_FLAGS ##1 $stable(err_now) |->
      S_AXI_RDATA[7:4] == err_now;
  endproperty
  a_err_view: assert property (p_err_view) else $error("error flags misread");
  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
  c_flags: cover property (S_AXI_RVALID && err_now != 4'h0);
  c_irq: cover property ($rose(IRQ));
endmodule
bind iorb_top iorb_properties u_props (.REF_CLK(REF_CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .TIMEOUT_ERROR_FLAG(TIMEOUT_ERROR_FLAG),
  .EXTERNAL_ALARM_FLAG(EXTERNAL_ALARM_FLAG), .DEVIATION_ERROR_FLAG(DEVIATION_ERROR_FLAG),
  .POSITION_ERROR_FLAG(POSITION_ERROR_FLAG), .IRQ(IRQ));

// ### test/iorb_line_env.sv
// far-side model: input lines, conversions, output states and error inputs
`timescale 1ns/1ps
module iorb_line_env (
  input wire logic [3:0] err_sel,
  output logic [3:0] level,
  output logic [15:0] adc_0,
  output logic [15:0] adc_1,
  output logic [15:0] adc_2,
  output logic [15:0] adc_3,
  output logic [3:0] out_state,
  output logic [3:0] err
);
  // levels chosen to disagree with each conversion's msb except on line 3
  assign level = 4'hA;
  assign adc_0 = 16'hFFFF;
  assign adc_1 = 16'h0000;
  assign adc_2 = 16'hC350;
  assign adc_3 = 16'h8001;
  assign out_state = 4'h6;
  assign err = err_sel;
endmodule

// ### test/tb.sv
// self-checking bench for the i/o read, accumulator and branch unit
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic [7:0] op; logic [31:0] opd; logic [31:0] acc;} iorb_row_s;
  localparam iorb_row_s ROWS [11] = '{'{8'h09, 32'h64, 32'h64}, '{8'h00, 32'h17, 32'h7B},
    '{8'h01, 32'hC8, 32'hFFFFFFB3}, '{8'h02, 32'hFFFFEC78, 32'h5DFE8}, '{8'h03, 32'h7, 32'hD6D8},
    '{8'h04, 32'h12C, 32'h64}, '{8'h05, 32'h3C, 32'h24}, '{8'h06, 32'hF00, 32'hF24},
    '{8'h07, 32'hFFF, 32'hDB}, '{8'h08, 32'h0, 32'hFFFFFF24}, '{8'h03, 32'hFFFFFFF6, 32'h16}};
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wr, bv, arr, rv, irq;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0, rdd, v, p, acc;
  logic [1:0] br, rr, lr, lb;
  logic [3:0] lvl, outs, errs, esel = 4'h0;
  logic [15:0] adc [4];
  int fails = 0, num_checks = 0, cyc = 0;
  initial forever #25 clk = ~clk;
  iorb_line_env env (.err_sel(esel), .level(lvl), .adc_0(adc[0]), .adc_1(adc[1]), .adc_2(adc[2]),
    .adc_3(adc[3]), .out_state(outs), .err(errs));
  iorb_top uut (.REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .INPUT_LINE_LEVEL(lvl),
    .INPUT_LINE_ADC_0(adc[0]), .INPUT_LINE_ADC_1(adc[1]), .INPUT_LINE_ADC_2(adc[2]),
    .INPUT_LINE_ADC_3(adc[3]), .OUTPUT_LINE_STATE(outs), .TIMEOUT_ERROR_FLAG(errs[0]),
    .EXTERNAL_ALARM_FLAG(errs[1]), .DEVIATION_ERROR_FLAG(errs[2]), .POSITION_ERROR_FLAG(errs[3]), .IRQ(irq));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      bry <= bv && !bry;
      n++;
    end while (!(bv && bry) && n < 64);
    lb = br;
    if (n >= 64) chk("write wait", 32'h1, 32'h0);
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      rry <= rv && !rry;
      n++;
    end while (!(rv && rry) && n < 64);
    v = rdd;
    lr = rr;
    if (n >= 64) chk("read wait", 32'h1, 32'h0);
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(nm, e, v & m);
  endtask
  task automatic cmd(input logic [7:0] ins, input logic [7:0] ty, input logic [7:0] bk, input logic [31:0] o);
    axw(iorb_pkg::OFS_OPERAND, o);
    axw(iorb_pkg::OFS_COMMAND, {8'h00, bk, ty, ins});
  endtask
  // flags f = {lower, greater, equal}, e = {position, deviation, alarm, timeout}
  function automatic logic taken(input logic [7:0] c, input logic [2:0] f, input logic [3:0] e);
    case (c)
      8'h00, 8'h02: return f[0];
      8'h01, 8'h03: return !f[0];
      8'h04: return f[1];
      8'h05: return f[1] | f[0];
      8'h06: return f[2];
      8'h07: return f[2] | f[0];
      default: return e[c[1:0]];
    endcase
  endfunction
  task automatic br_chk(input logic [7:0] c, input logic [2:0] f, input logic [3:0] e);
    rd(iorb_pkg::OFS_PROG_COUNTER);
    p = v;
    cmd(8'h15, c, 8'h00, 32'h200);
    rchk("pc", iorb_pkg::OFS_PROG_COUNTER, ALL, taken(c, f, e) ? 32'h200 : p + 32'h1);
    rchk("flags", iorb_pkg::OFS_FLAGS, 32'h7, {29'h0, f});
    rchk("acc kept", iorb_pkg::OFS_ACCUM, ALL, acc);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // whole run needs about two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk("acc rst", iorb_pkg::OFS_ACCUM, ALL, 32'h0);
    rchk("pc rst", iorb_pkg::OFS_PROG_COUNTER, ALL, 32'h0);
    rchk("mask rst", iorb_pkg::OFS_IRQ_MASK, ALL, 32'h0);
    foreach (ROWS[i]) begin
      cmd(8'h13, ROWS[i].op, 8'h00, ROWS[i].opd);
      rchk("status", iorb_pkg::OFS_REPLY_STATUS, 32'h1FF, 32'h64);
      rchk("echo", iorb_pkg::OFS_REPLY_VALUE, ALL, ROWS[i].opd);
      rchk("acc", iorb_pkg::OFS_ACCUM, ALL, ROWS[i].acc);
    end
    acc = ROWS[10].acc;
    for (int b = 0; b < 3; b++) begin
      for (int k = 0; k < 4; k++) begin
        cmd(8'h0F, 8'(k), 8'(b), 32'h0);
        p = b == 0 ? 32'(lvl[k]) : b == 1 ? 32'(adc[k]) : 32'(outs[k]);
        rchk("port", iorb_pkg::OFS_REPLY_VALUE, ALL, p);
      end
    end
    rchk("direct acc", iorb_pkg::OFS_ACCUM, ALL, acc);
    cmd(8'h0F, 8'h00, 8'h03, 32'h0);
    rchk("bad bank", iorb_pkg::OFS_REPLY_STATUS, 32'hFF, 32'h02);
    cmd(8'h15, 8'h00, 8'h00, 32'h200);
    rchk("direct branch", iorb_pkg::OFS_REPLY_STATUS, 32'hFF, 32'h02);
    chk("irq masked", 32'h0, {31'h0, irq});
    axw(iorb_pkg::OFS_CTRL, 32'h1);
    cmd(8'h0F, 8'h02, 8'h01, 32'h0);
    acc = {16'h0, adc[2]};
    rchk("stored acc", iorb_pkg::OFS_ACCUM, ALL, acc);
    for (int k = 0; k < 3; k++) begin
      cmd(8'h14, 8'h00, 8'h00, acc + 32'h1 - 32'(k));
      for (int c = 0; c < 8; c++) br_chk(8'(c), {k == 0, k == 2, k == 1}, 4'h0);
    end
    for (int k = 0; k < 4; k++) begin
      esel <= 4'h1 << k;
      @(posedge clk);
      for (int c = 8; c < 12; c++) br_chk(8'(c), 3'b010, 4'h1 << k);
    end
    esel <= 4'h0;
    axw(iorb_pkg::OFS_IRQ_MASK, 32'h7);
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    rchk("irq status", iorb_pkg::OFS_IRQ_STATUS, ALL, 32'h7);
    repeat (3) @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    axw(iorb_pkg::OFS_IRQ_MASK, 32'h2);
    cmd(8'h14, 8'h00, 8'h00, 32'h0);
    repeat (3) @(posedge clk);
    chk("irq mask", 32'h0, {31'h0, irq});
    rd(12'h040);
    chk("unmapped rresp", 32'h2, {30'h0, lr});
    chk("unmapped data", 32'h0, v);
    axw(12'h040, 32'h1);
    chk("unmapped bresp", 32'h2, {30'h0, lb});
    tally_and_finish();
  end
endmodule
